// [counter_array_pkg.sv]
// constants, register map and carrier types of the counter array configuration block
package counter_array_pkg;
    // number of modules the register map provides addresses for
    localparam int MAX_MODULES = 3;
    // module that turns into the watchdog while the watchdog is enabled
    localparam int WATCHDOG_MODULE = 2;

    // register byte addresses in the special-function space
    localparam logic [7:0] MODE_ADDR     [MAX_MODULES] = '{8'hda, 8'hdb, 8'hdc};
    localparam logic [7:0] CMP_LOW_ADDR  [MAX_MODULES] = '{8'hfb, 8'he9, 8'heb};
    localparam logic [7:0] CMP_HIGH_ADDR [MAX_MODULES] = '{8'hfc, 8'hea, 8'hec};
    localparam logic [7:0] PWM_CFG_ADDR  = 8'hf7;
    localparam logic [7:0] FLAG_ADDR     = 8'hd8;

    // reset values
    localparam logic [7:0]  MODE_RESET    = 8'h00;
    localparam logic [7:0]  PWM_CFG_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET     = 16'h0000;

    // cycle length select codes
    localparam logic [1:0] LEN_8  = 2'h0;
    localparam logic [1:0] LEN_9  = 2'h1;
    localparam logic [1:0] LEN_10 = 2'h2;
    localparam logic [1:0] LEN_11 = 2'h3;

    // counter masks for each cycle length
    localparam logic [15:0] MASK_8  = 16'h00ff;
    localparam logic [15:0] MASK_9  = 16'h01ff;
    localparam logic [15:0] MASK_10 = 16'h03ff;
    localparam logic [15:0] MASK_11 = 16'h07ff;
    localparam logic [15:0] MASK_16 = 16'hffff;

    // per-module mode register layout, msb first
    typedef struct packed {
        logic wideSel;   // 16-bit pwm instead of 8 to 11-bit
        logic compEn;    // comparator enable
        logic riseCap;   // capture on rising pin edge
        logic fallCap;   // capture on falling pin edge
        logic matchEn;   // match sets the event flag
        logic toggleEn;  // match toggles the pin
        logic pwmEn;     // pwm waveform on the pin
        logic irqEn;     // event flag requests the interrupt
    } mode_t;

    // pwm cycle configuration layout, msb first
    typedef struct packed {
        logic       bankSel;    // 1: compare addresses reach the reload bank
        logic       wrapIrqEn;  // cycle wrap interrupt enable
        logic       wrapFlag;   // sticky cycle wrap flag
        logic [2:0] unused;     // always zero
        logic [1:0] lengthSel;  // cycle length select
    } pwm_cfg_t;

    // register port request from the cpu side
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;
endpackage

// [counter_array_pwm_config.sv]
// capture, compare and pwm mode logic of a three-module counter array
module counter_array_pwm_config
    import counter_array_pkg::*;
#(
    parameter int NUM_MODULES = 3  // modules implemented
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire reg_req_t               regReq,
    output logic [7:0]                  regRdata,
    input  wire logic [15:0]            mainCounter,
    input  wire logic                   counterOverflowFlag,
    input  wire logic                   counterOverflowIrqEnable,
    input  wire logic                   watchdogEnable,
    input  wire logic [NUM_MODULES-1:0] modulePinIn,
    output logic [NUM_MODULES-1:0]      modulePinOut,
    output logic [NUM_MODULES-1:0]      modulePinOe_b,
    output logic                        irqRequest
);

    // the address map only holds three modules
    if (NUM_MODULES < 1 || NUM_MODULES > MAX_MODULES) begin : g_badCount
        $error("NUM_MODULES must lie between 1 and 3");
    end

    // register state
    mode_t                    mode      [NUM_MODULES];  // module mode registers
    mode_t                    next_mode [NUM_MODULES];
    logic [15:0]              cmp       [NUM_MODULES];  // capture/compare registers
    logic [15:0]              next_cmp  [NUM_MODULES];
    logic [15:0]              reload      [NUM_MODULES];  // auto-reload registers
    logic [15:0]              next_reload [NUM_MODULES];
    logic [NUM_MODULES-1:0]   eventFlag;                 // sticky module event flags
    logic [NUM_MODULES-1:0]   next_eventFlag;
    pwm_cfg_t                 cfg;                       // pwm cycle configuration
    pwm_cfg_t                 next_cfg;
    logic [NUM_MODULES-1:0]   next_pinOut;
    logic [NUM_MODULES-1:0]   next_pinOe_b;
    logic [7:0]               next_rdata;

    // pin synchronisers and filtered levels
    logic [NUM_MODULES-1:0]   syncA;      // first stage, read only by syncB
    logic [NUM_MODULES-1:0]   syncB;
    logic [NUM_MODULES-1:0]   syncC;
    logic [NUM_MODULES-1:0]   pinLevel;   // level accepted once syncB and syncC agree
    logic [NUM_MODULES-1:0]   next_pinLevel;
    logic [NUM_MODULES-1:0]   pinRise;
    logic [NUM_MODULES-1:0]   pinFall;

    // counter history, used to turn equality into a one-shot event
    logic [15:0]              prevCounter;
    logic                     counterMoved;
    logic [15:0]              cycleMask;
    logic                     wrapEvent;

    // per-module combinational events
    logic [NUM_MODULES-1:0]   matchHit;   // full 16-bit equality, once per count
    logic [NUM_MODULES-1:0]   lowHit;     // low-byte equality for frequency output
    logic [NUM_MODULES-1:0]   captureHit;
    logic [NUM_MODULES-1:0]   active;     // module not taken over by the watchdog
    logic [NUM_MODULES-1:0]   pwmLevel;
    logic [NUM_MODULES-1:0]   flagIrq;

    // pin filter: a change counts only when the last two stages agree
    always_comb begin
        next_pinLevel = pinLevel;
        for (int i = 0; i < NUM_MODULES; i++) begin
            if (syncB[i] == syncC[i]) begin
                next_pinLevel[i] = syncC[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            // released pins idle at their pull-up level; starting low would fake a
            // rising edge a few cycles after reset
            syncA       <= '1;
            syncB       <= '1;
            syncC       <= '1;
            pinLevel    <= '1;
            prevCounter <= 16'h0000;
        end else begin
            syncA       <= modulePinIn;
            syncB       <= syncA;
            syncC       <= syncB;
            pinLevel    <= next_pinLevel;
            prevCounter <= mainCounter;
        end
    end

    // cycle length mask; code 11 completes the field with 11 bits
    always_comb begin
        unique case (cfg.lengthSel)
            LEN_8:   cycleMask = MASK_8;
            LEN_9:   cycleMask = MASK_9;
            LEN_10:  cycleMask = MASK_10;
            LEN_11:  cycleMask = MASK_11;
            default: cycleMask = MASK_8;
        endcase
    end

    // a counter that stands still must not repeat a match every cycle
    assign counterMoved = (mainCounter != prevCounter);
    // wrap: the masked bits went from all ones to all zeros
    assign wrapEvent = counterMoved && ((prevCounter & cycleMask) == cycleMask)
                       && ((mainCounter & cycleMask) == 16'h0000);

    // per-module event detection
    for (genvar g = 0; g < NUM_MODULES; g++) begin : g_module
        assign active[g]     = !((g == WATCHDOG_MODULE) && watchdogEnable);
        assign pinRise[g]    = next_pinLevel[g] && !pinLevel[g];
        assign pinFall[g]    = !next_pinLevel[g] && pinLevel[g];
        assign captureHit[g] = active[g] && ((mode[g].riseCap && pinRise[g])
                               || (mode[g].fallCap && pinFall[g]));
        assign matchHit[g]   = active[g] && mode[g].compEn && counterMoved
                               && (mainCounter == cmp[g]);
        assign lowHit[g]     = active[g] && mode[g].compEn
                               && (mainCounter[7:0] != prevCounter[7:0])
                               && (mainCounter[7:0] == cmp[g][7:0]);
        // 16-bit pwm compares the full counter and ignores the length field
        assign pwmLevel[g]   = mode[g].wideSel ? (mainCounter >= cmp[g])
                               : ((mainCounter & cycleMask) >= (cmp[g] & cycleMask));
        assign flagIrq[g]    = mode[g].irqEn && eventFlag[g];
    end

    // register next values: bus writes first, hardware events after so sets win
    always_comb begin
        next_cfg       = cfg;
        next_eventFlag = eventFlag;
        next_pinOut    = modulePinOut;
        next_pinOe_b   = modulePinOe_b;
        for (int i = 0; i < NUM_MODULES; i++) begin
            next_mode[i]   = mode[i];
            next_cmp[i]    = cmp[i];
            next_reload[i] = reload[i];
        end

        // configuration register; the unused field is never stored
        if (regReq.wr && regReq.addr == PWM_CFG_ADDR) begin
            next_cfg        = pwm_cfg_t'(regReq.wdata);
            next_cfg.unused = 3'h0;
        end
        // software may set or clear the wrap flag, hardware only sets it
        if (wrapEvent) begin
            next_cfg.wrapFlag = 1'b1;
        end

        for (int i = 0; i < NUM_MODULES; i++) begin
            // mode register, frozen for the watchdog module while it guards
            if (regReq.wr && regReq.addr == MODE_ADDR[i] && active[i]) begin
                next_mode[i] = mode_t'(regReq.wdata);
            end
            // compare low byte: bank select picks compare or reload storage
            if (regReq.wr && regReq.addr == CMP_LOW_ADDR[i]) begin
                if (cfg.bankSel) begin
                    next_reload[i][7:0] = regReq.wdata;
                end else begin
                    next_cmp[i][7:0] = regReq.wdata;
                end
                if (active[i]) begin
                    next_mode[i].compEn = 1'b0;
                end
            end
            // compare high byte
            if (regReq.wr && regReq.addr == CMP_HIGH_ADDR[i]) begin
                if (cfg.bankSel) begin
                    next_reload[i][15:8] = regReq.wdata;
                end else begin
                    next_cmp[i][15:8] = regReq.wdata;
                end
                if (active[i]) begin
                    next_mode[i].compEn = 1'b1;
                end
            end
            // event flags clear only by a software zero
            if (regReq.wr && regReq.addr == FLAG_ADDR && !regReq.wdata[i]) begin
                next_eventFlag[i] = 1'b0;
            end

            // reload at each cycle wrap in 9 to 11-bit pwm only
            if (active[i] && mode[i].pwmEn && !mode[i].toggleEn && !mode[i].wideSel
                && cfg.lengthSel != LEN_8 && wrapEvent) begin
                next_cmp[i] = reload[i];
            end
            // a capture overrides a software write to the compare register or flags in the same cycle
            if (captureHit[i]) begin
                next_cmp[i]       = mainCounter;
                next_eventFlag[i] = 1'b1;
            end
            if (mode[i].matchEn && matchHit[i]) begin
                next_eventFlag[i] = 1'b1;
            end

            // pin output
            if (!active[i]) begin
                next_pinOe_b[i] = 1'b1;
                next_pinOut[i]  = 1'b0;
            end else if (mode[i].toggleEn && mode[i].pwmEn) begin
                next_pinOe_b[i] = 1'b0;
                if (lowHit[i]) begin
                    next_pinOut[i] = !modulePinOut[i];
                end
            end else if (mode[i].pwmEn) begin
                next_pinOe_b[i] = 1'b0;
                next_pinOut[i]  = pwmLevel[i];
            end else if (mode[i].toggleEn) begin
                next_pinOe_b[i] = 1'b0;
                if (matchHit[i]) begin
                    next_pinOut[i] = !modulePinOut[i];
                end
            end else begin
                // pin released so it can serve as a capture input
                next_pinOe_b[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg           <= pwm_cfg_t'(PWM_CFG_RESET);
            eventFlag     <= '0;
            modulePinOut  <= '0;
            modulePinOe_b <= '1;
            for (int i = 0; i < NUM_MODULES; i++) begin
                mode[i]   <= mode_t'(MODE_RESET);
                cmp[i]    <= CMP_RESET;
                reload[i] <= CMP_RESET;
            end
        end else begin
            cfg           <= next_cfg;
            eventFlag     <= next_eventFlag;
            modulePinOut  <= next_pinOut;
            modulePinOe_b <= next_pinOe_b;
            for (int i = 0; i < NUM_MODULES; i++) begin
                mode[i]   <= next_mode[i];
                cmp[i]    <= next_cmp[i];
                reload[i] <= next_reload[i];
            end
        end
    end

    // read data, registered so it stands in the cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        if (regReq.rd) begin
            if (regReq.addr == PWM_CFG_ADDR) begin
                next_rdata = {cfg.bankSel, cfg.wrapIrqEn, cfg.wrapFlag, 3'h0,
                              cfg.lengthSel};
            end
            if (regReq.addr == FLAG_ADDR) begin
                next_rdata[NUM_MODULES-1:0] = eventFlag;
            end
            for (int i = 0; i < NUM_MODULES; i++) begin
                if (regReq.addr == MODE_ADDR[i]) begin
                    next_rdata = mode[i];
                end
                if (regReq.addr == CMP_LOW_ADDR[i]) begin
                    next_rdata = cfg.bankSel ? reload[i][7:0] : cmp[i][7:0];
                end
                if (regReq.addr == CMP_HIGH_ADDR[i]) begin
                    next_rdata = cfg.bankSel ? reload[i][15:8] : cmp[i][15:8];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= next_rdata;
        end
    end

    // interrupt request from all enabled sources
    assign irqRequest = (cfg.wrapIrqEn && cfg.wrapFlag)
                        || (counterOverflowIrqEnable && counterOverflowFlag)
                        || (|flagIrq);

    // checks on module 0 and the shared configuration
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_bankRead;
        regReq.rd && regReq.addr == CMP_LOW_ADDR[0] && !cfg.bankSel && !captureHit[0]
        |=> regRdata == $past(cmp[0][7:0]);
    endproperty
    a_bankRead: assert property (p_bankRead) else $error("compare low read wrong");

    property p_noReload8;
        !regReq.wr && !captureHit[0] && cfg.lengthSel == LEN_8 |=> $stable(cmp[0]);
    endproperty
    a_noReload8: assert property (p_noReload8) else $error("compare moved in 8-bit");

    property p_wrapIrq;
        cfg.wrapIrqEn && cfg.wrapFlag |-> irqRequest;
    endproperty
    a_wrapIrq: assert property (p_wrapIrq) else $error("wrap irq missing");

    // the flag must follow every wrap one cycle later
    property p_wrapSet;
        wrapEvent |=> cfg.wrapFlag;
    endproperty
    a_wrapSet: assert property (p_wrapSet) else $error("wrap flag not set");

    property p_wrapSticky;
        $fell(cfg.wrapFlag) |-> $past(regReq.wr) && $past(regReq.addr) == PWM_CFG_ADDR;
    endproperty
    a_wrapSticky: assert property (p_wrapSticky) else $error("wrap flag cleared by hw");

    property p_reservedZero;
        regReq.rd && regReq.addr == PWM_CFG_ADDR |=> regRdata[4:2] == 3'h0;
    endproperty
    a_reservedZero: assert property (p_reservedZero) else $error("unused bits nonzero");

    property p_eventSticky;
        $fell(eventFlag[0]) |-> $past(regReq.wr) && $past(regReq.addr) == FLAG_ADDR;
    endproperty
    a_eventSticky: assert property (p_eventSticky) else $error("event flag cleared by hw");

    property p_capture;
        captureHit[0] |=> cmp[0] == $past(mainCounter) && eventFlag[0];
    endproperty
    a_capture: assert property (p_capture) else $error("capture not taken");

    property p_lowClear;
        regReq.wr && regReq.addr == CMP_LOW_ADDR[0] |=> !mode[0].compEn;
    endproperty
    a_lowClear: assert property (p_lowClear) else $error("comparator not cleared");

    property p_highSet;
        regReq.wr && regReq.addr == CMP_HIGH_ADDR[0] |=> mode[0].compEn ##1 1'b1;
    endproperty
    a_highSet: assert property (p_highSet) else $error("comparator not set");

    property p_flagIrq;
        mode[0].irqEn && eventFlag[0] |-> irqRequest;
    endproperty
    a_flagIrq: assert property (p_flagIrq) else $error("event irq missing");

    // main scenarios
    c_wrap:    cover property (wrapEvent ##1 cfg.wrapFlag);
    c_capture: cover property (captureHit[0] ##[1:20] regReq.rd);
    c_toggle:  cover property (matchHit[0] && mode[0].toggleEn ##1 $changed(modulePinOut[0]));
    c_reload:  cover property (wrapEvent && mode[0].pwmEn && cfg.lengthSel == LEN_10);

endmodule // counter_array_pwm_config

// [pin_partner.sv]
// external pin model: resolves each module pin from the block's drive and an outside source
module pin_partner
    import counter_array_pkg::*;
#(
    parameter int N = 3  // pins modelled
) (
    input  wire logic [N-1:0] pinOut,   // value the block drives
    input  wire logic [N-1:0] pinOe_b,  // low while the block drives
    input  wire logic [N-1:0] extEn,    // outside source drives the pin
    input  wire logic [N-1:0] extLvl,   // level of the outside source
    output logic      [N-1:0] pinIn     // resolved wire level
);
    timeunit 1ns;
    timeprecision 1ps;
    // block drive wins; an undriven pin floats to its pull-up level, never to a stale value
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (!pinOe_b[i]) begin
                pinIn[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinIn[i] = extLvl[i];
            end else begin
                pinIn[i] = 1'b1;
            end
        end
    end
endmodule // pin_partner

// [tb.sv]
// self-checking bench: register access, compare, capture, wrap and pwm scenarios
`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin errTotal++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb
    import counter_array_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk;         // 100 MHz clock
    logic        rst_b;        // async reset, active low
    reg_req_t    regReq;       // register port request
    logic [7:0]  regRdata;     // read data, one cycle after the strobe
    logic [15:0] mainCounter;  // counter value fed by the bench
    logic        ovfFlag;      // outside overflow flag
    logic        ovfEn;        // outside overflow enable
    logic        wdEn;         // watchdog enable
    logic [2:0]  pinIn;        // resolved pin levels
    logic [2:0]  pinOut;       // block pin values
    logic [2:0]  pinOe_b;      // block pin enables, active low
    logic [2:0]  extLvl;       // outside pin drive
    logic        irqRequest;   // interrupt request
    int          errTotal;     // mismatches
    int          nTests;       // comparisons
    logic [15:0] msk;          // counter mask of the current length
    counter_array_pwm_config #(.NUM_MODULES(3)) uut (.mclk(mclk), .rst_b(rst_b),
        .regReq(regReq), .regRdata(regRdata), .mainCounter(mainCounter),
        .counterOverflowFlag(ovfFlag), .counterOverflowIrqEnable(ovfEn),
        .watchdogEnable(wdEn), .modulePinIn(pinIn), .modulePinOut(pinOut),
        .modulePinOe_b(pinOe_b), .irqRequest(irqRequest));
    pin_partner #(.N(3)) pins (.pinOut(pinOut), .pinOe_b(pinOe_b), .extEn(3'b111),
        .extLvl(extLvl), .pinIn(pinIn));
    always #5 mclk = ~mclk;
    // one write cycle; an idle cycle follows so strobes never get assigned twice at one edge;
    // returns just past the taking edge so registered state can be looked at right away
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        regReq.wr <= 1'b0;
        #1;
    endtask
    // one read cycle, data compared in the single cycle where it stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        regReq.rd <= 1'b0;
        #1;
        `CHK("read data", exp, regRdata)
    endtask
    // new counter value, then time for flags and pins to settle
    task automatic setc(input logic [15:0] v);
        @(posedge mclk);
        mainCounter <= v;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // bounded wait for the interrupt; running out ends the run
    task automatic waitIrq();
        int k;
        for (k = 0; k < 20 && irqRequest !== 1'b1; k++) @(posedge mclk);
        if (irqRequest !== 1'b1) begin
            errTotal++;
            wrapUp();
        end
    endtask
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        mclk = 0; rst_b = 0; regReq = '0; mainCounter = '0;
        ovfFlag = 0; ovfEn = 0; wdEn = 0; extLvl = 3'b111; errTotal = 0; nTests = 0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        // reset values, unmapped address reads zero
        for (int i = 0; i < MAX_MODULES; i++) begin
            rd(MODE_ADDR[i], MODE_RESET);
        end
        rd(PWM_CFG_ADDR, PWM_CFG_RESET);
        rd(8'h00, 8'h00);
        // unused bits stay zero; software sets the wrap flag and it interrupts
        wr(PWM_CFG_ADDR, 8'hff);
        rd(PWM_CFG_ADDR, 8'he3);
        `CHK("irq", 1'b1, irqRequest)
        wr(PWM_CFG_ADDR, 8'h43);
        `CHK("irq", 1'b0, irqRequest)
        // reload bank behind the same compare address
        wr(CMP_LOW_ADDR[0], 8'h34);
        wr(PWM_CFG_ADDR, 8'h80);
        wr(CMP_LOW_ADDR[0], 8'h56);
        rd(CMP_LOW_ADDR[0], 8'h56);
        wr(PWM_CFG_ADDR, 8'h00);
        rd(CMP_LOW_ADDR[0], 8'h34);
        // compare byte writes arm and disarm the comparator
        wr(CMP_HIGH_ADDR[0], 8'h00);
        rd(MODE_ADDR[0], 8'h40);
        wr(CMP_LOW_ADDR[0], 8'h10);
        rd(MODE_ADDR[0], 8'h00);
        // match with interrupt on module 0
        wr(MODE_ADDR[0], 8'h09);
        wr(CMP_HIGH_ADDR[0], 8'h00);
        rd(MODE_ADDR[0], 8'h49);
        `CHK("irq", 1'b0, irqRequest)
        setc(16'h000f);
        setc(16'h0010);
        waitIrq();
        rd(FLAG_ADDR, 8'h01);
        wr(MODE_ADDR[0], 8'h08);
        `CHK("irq", 1'b0, irqRequest)
        rd(FLAG_ADDR, 8'h01);
        wr(FLAG_ADDR, 8'h00);
        rd(FLAG_ADDR, 8'h00);
        // toggle on module 1
        wr(CMP_LOW_ADDR[1], 8'h20);
        wr(MODE_ADDR[1], 8'h44);
        @(posedge mclk);
        #1;
        `CHK("oe1", 1'b0, pinOe_b[1])
        setc(16'h0020);
        `CHK("pin1", 1'b1, pinIn[1])
        setc(16'h0021);
        setc(16'h0020);
        `CHK("pin1", 1'b0, pinIn[1])
        // capture on both pin edges of module 0
        wr(MODE_ADDR[0], 8'h31);
        setc(16'h1234);
        extLvl[0] <= 1'b0;
        waitIrq();
        rd(CMP_LOW_ADDR[0], 8'h34);
        rd(CMP_HIGH_ADDR[0], 8'h12);
        wr(FLAG_ADDR, 8'h00);
        setc(16'h5678);
        extLvl[0] <= 1'b1;
        waitIrq();
        rd(CMP_LOW_ADDR[0], 8'h78);
        rd(CMP_HIGH_ADDR[0], 8'h56);
        wr(MODE_ADDR[0], 8'h00);
        // wrap flag follows the selected length only
        for (int l = 0; l < 4; l++) begin
            msk = (16'h0100 << l) - 16'h0001;
            wr(PWM_CFG_ADDR, 8'(l));
            setc(16'h00fe);
            setc(16'h00ff);
            setc(16'h0100);
            rd(PWM_CFG_ADDR, {2'b00, l == 0, 3'b000, 2'(l)});
            wr(PWM_CFG_ADDR, 8'(l));
            setc(msk - 16'h0001);
            setc(msk);
            setc(msk + 16'h0001);
            rd(PWM_CFG_ADDR, {2'b00, 1'b1, 3'b000, 2'(l)});
        end
        // pwm on module 2, narrow then wide
        wr(PWM_CFG_ADDR, 8'h00);
        wr(CMP_LOW_ADDR[2], 8'h80);
        wr(CMP_HIGH_ADDR[2], 8'h10);
        wr(MODE_ADDR[2], 8'h42);
        setc(16'h0f90);
        `CHK("pin2", 1'b1, pinIn[2])
        setc(16'h0f10);
        `CHK("pin2", 1'b0, pinIn[2])
        wr(MODE_ADDR[2], 8'hc2);
        setc(16'h0f90);
        `CHK("pin2", 1'b0, pinIn[2])
        setc(16'h1090);
        `CHK("pin2", 1'b1, pinIn[2])
        // reload in 9-bit pwm at the cycle wrap
        wr(PWM_CFG_ADDR, 8'h81);
        wr(CMP_LOW_ADDR[2], 8'h55);
        wr(CMP_HIGH_ADDR[2], 8'h01);
        wr(PWM_CFG_ADDR, 8'h01);
        wr(MODE_ADDR[2], 8'h42);
        setc(16'h01ff);
        setc(16'h0200);
        rd(CMP_LOW_ADDR[2], 8'h55);
        rd(CMP_HIGH_ADDR[2], 8'h01);
        // watchdog locks module 2 and releases its pin
        wdEn <= 1'b1;
        wr(MODE_ADDR[2], 8'h00);
        rd(MODE_ADDR[2], 8'h42);
        `CHK("oe2", 1'b1, pinOe_b[2])
        wdEn <= 1'b0;
        wr(MODE_ADDR[2], 8'h00);
        rd(MODE_ADDR[2], 8'h00);
        // frequency output on module 1 toggles on low-byte matches only
        wr(MODE_ADDR[1], 8'h46);
        setc(16'h3420);
        `CHK("pin1", 1'b1, pinIn[1])
        setc(16'h3521);
        setc(16'h3620);
        `CHK("pin1", 1'b0, pinIn[1])
        // outside overflow joins the request
        ovfFlag <= 1'b1;
        ovfEn <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK("irq", 1'b1, irqRequest)
        wrapUp();
    end
endmodule // tb
